// [logic/swsm_divider.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Serial restoring divider, one quotient bit per cycle
module swsm_divider #(
  parameter int W = 48
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         start,
  input  wire logic [W-1:0] num,
  input  wire logic [W-1:0] den,
  output logic              done,
  output logic [W-1:0]      quo
);
  localparam int CW = $clog2(W + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(W - 1);

  logic [W:0]    rem;
  logic [W-1:0]  den_q;
  logic [CW-1:0] cnt;
  logic          busy;
  logic [W:0]    rem_sh;

  assign rem_sh = {rem[W-1:0], quo[W-1]};

  // Zero divisor yields all ones, which callers treat as saturation
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rem   <= '0;
      den_q <= '0;
      quo   <= '0;
      cnt   <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        rem   <= '0;
        quo   <= num;
        den_q <= den;
        cnt   <= '0;
        busy  <= 1'b1;
      end else if (busy) begin
        if (rem_sh >= {1'b0, den_q}) begin
          rem <= rem_sh - {1'b0, den_q};
          quo <= {quo[W-2:0], 1'b1};
        end else begin
          rem <= rem_sh;
          quo <= {quo[W-2:0], 1'b0};
        end
        if (cnt == CNT_LAST) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [logic/swsm_monitor.sv]
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Window true while speed inside limits
// - Above high limit window goes false
// - Below low limit window goes false
// - Zero output true below standstill limit
// - Release threshold is upper minus hysteresis
// - Direction 1 counterclockwise, 0 clockwise
// - Direction only with an encoder present
// - Five selectable measuring arrangements
// - Primary resolution pulses/rev or um/pulse
// - Second sensor has own resolution
// - Gear ratio scales two-sensor comparison
// - Rotary axis: rpm/60 times pulses/rev
// - Linear/rotary: m/min*1000/(60*pitch)*ppr
// - Linear/linear: mm/s*1000 over um/pulse
// - Optional diagnostic error output
// - Optional measured frequency output
// - Unavailable sensor saturates 650kHz or 0
// - Analog check off: plausibility only
// - Error on missing, supply, mismatch, phase
module swsm_monitor #(
  parameter int GATE_CYCLES = swsm_pkg::GATE_CYCLES_DEF
) (
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  input  wire logic [swsm_pkg::ADDR_W-1:0]  addr,
  input  wire logic [swsm_pkg::DATA_W-1:0]  wdata,
  input  wire logic                         wr_en,
  input  wire logic                         rd_en,
  output logic [swsm_pkg::DATA_W-1:0]       rdata,
  input  wire swsm_pkg::swsm_pins_t         pins,
  output logic                              window_out,
  output logic                              zero_out,
  output logic                              dir_out,
  output logic                              error_out,
  output logic [swsm_pkg::FREQ_W-1:0]       speed_freq_out
);
  localparam int NW = swsm_pkg::NUM_W;
  localparam int WW = swsm_pkg::WIDE_W;
  localparam int FW = swsm_pkg::FREQ_W;
  localparam int GW = $clog2(GATE_CYCLES + 1);
  localparam logic [GW-1:0] GATE_LAST = GW'(GATE_CYCLES - 1);
  localparam logic [FW-1:0] FREQ_MAX  = '1;
  localparam logic [FW-1:0] FREQ_SAT  = FW'(swsm_pkg::SAT_HIGH_HZ);
  localparam logic [2:0]    STEP_LAST = 3'(swsm_pkg::N_STEPS - 1);

  typedef enum logic [1:0] {CALC_IDLE, CALC_LOAD, CALC_WAIT} swsm_calc_t;

  // ==========================================================
  // Configuration registers
  swsm_pkg::swsm_cfg_t                  cfg;
  logic [swsm_pkg::RES_W-1:0]           res1;
  logic [swsm_pkg::RES_W-1:0]           res2;
  logic [swsm_pkg::GEAR_W-1:0]          gear;
  logic [swsm_pkg::RES_W-1:0]           pitch;
  logic [swsm_pkg::HYST_W-1:0]          hyst;
  logic [swsm_pkg::SPEED_W-1:0]         spd_lim [swsm_pkg::N_LIMITS];
  logic                                 cfg_wr;
  logic                                 recalc_req;

  assign cfg_wr = wr_en && (addr != swsm_pkg::OFF_STATUS) && (addr != swsm_pkg::OFF_FREQ);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg   <= swsm_pkg::swsm_cfg_t'(swsm_pkg::CFG_RESET);
      res1  <= swsm_pkg::RES_RESET;
      res2  <= swsm_pkg::RES_RESET;
      gear  <= swsm_pkg::GEAR_RESET;
      pitch <= swsm_pkg::PITCH_RESET;
      hyst  <= swsm_pkg::HYST_RESET;
      for (int i = 0; i < swsm_pkg::N_LIMITS; i++) begin
        spd_lim[i] <= swsm_pkg::SPEED_RESET;
      end
    end else if (ce && wr_en) begin
      case (addr)
        swsm_pkg::OFF_CTRL:  cfg   <= swsm_pkg::swsm_cfg_t'(wdata[swsm_pkg::CFG_W-1:0]);
        swsm_pkg::OFF_RES1:  res1  <= wdata[swsm_pkg::RES_W-1:0];
        swsm_pkg::OFF_RES2:  res2  <= wdata[swsm_pkg::RES_W-1:0];
        swsm_pkg::OFF_GEAR:  gear  <= wdata[swsm_pkg::GEAR_W-1:0];
        swsm_pkg::OFF_PITCH: pitch <= wdata[swsm_pkg::RES_W-1:0];
        swsm_pkg::OFF_HYST:  hyst  <= wdata[swsm_pkg::HYST_W-1:0];
        swsm_pkg::OFF_HIGH:  spd_lim[swsm_pkg::LIMIT_HI]   <= wdata[swsm_pkg::SPEED_W-1:0];
        swsm_pkg::OFF_LOW:   spd_lim[swsm_pkg::LIMIT_LO]   <= wdata[swsm_pkg::SPEED_W-1:0];
        swsm_pkg::OFF_ZERO:  spd_lim[swsm_pkg::LIMIT_ZERO] <= wdata[swsm_pkg::SPEED_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Arrangement decode
  logic has_enc1;
  logic has_s2;
  logic s2_enc;

  always_comb begin
    has_enc1 = 1'b0;
    has_s2   = 1'b0;
    s2_enc   = 1'b0;
    case (cfg.mdev)
      swsm_pkg::SWSM_MD_ENC:       has_enc1 = 1'b1;
      swsm_pkg::SWSM_MD_ENC_PROX:  begin has_enc1 = 1'b1; has_s2 = 1'b1; end
      swsm_pkg::SWSM_MD_PROX_PROX: has_s2 = 1'b1;
      swsm_pkg::SWSM_MD_ENC_ENC:   begin has_enc1 = 1'b1; has_s2 = 1'b1; s2_enc = 1'b1; end
      default: ;
    endcase
  end

  // ==========================================================
  // Threshold conversion, recomputed after any setting change
  swsm_calc_t                  calc_st;
  logic [2:0]                  step;
  logic                        div_start;
  logic                        div_done;
  logic [NW-1:0]               div_quo;
  logic [NW-1:0]               div_num;
  logic [NW-1:0]               div_den;
  logic [FW-1:0]               quo_sat;
  logic [FW-1:0]               up_thr  [swsm_pkg::N_LIMITS];
  logic [FW-1:0]               rel_thr [swsm_pkg::N_LIMITS];
  logic [NW-1:0]               spd_n;
  logic [1:0]                  lim_idx;

  assign lim_idx = step[2:1];
  assign spd_n   = NW'(spd_lim[lim_idx]);
  assign quo_sat = (div_quo > NW'(FREQ_MAX)) ? FREQ_MAX : div_quo[FW-1:0];

  always_comb begin
    div_num = '0;
    div_den = '0;
    if (step[0]) begin
      div_num = NW'(up_thr[lim_idx]) * NW'(hyst);
      div_den = NW'(swsm_pkg::PERCENT);
    end else if (!cfg.axis_linear) begin
      div_num = spd_n * NW'(res1);
      div_den = NW'(swsm_pkg::SEC_PER_MIN);
    end else if (!cfg.sensor_linear) begin
      div_num = spd_n * NW'(swsm_pkg::MILLI) * NW'(res1);
      div_den = NW'(swsm_pkg::SEC_PER_MIN) * NW'(pitch);
    end else begin
      div_num = spd_n * NW'(swsm_pkg::MILLI);
      div_den = NW'(res1);
    end
  end

  swsm_divider #(
    .W (NW)
  ) u_div (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .start (div_start),
    .num   (div_num),
    .den   (div_den),
    .done  (div_done),
    .quo   (div_quo)
  );

  // Request set wins over the clear taken when a pass starts
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      recalc_req <= 1'b1;
    end else if (ce) begin
      if (cfg_wr) begin
        recalc_req <= 1'b1;
      end else if (calc_st == CALC_IDLE) begin
        recalc_req <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      calc_st   <= CALC_IDLE;
      step      <= '0;
      div_start <= 1'b0;
    end else if (ce) begin
      div_start <= 1'b0;
      case (calc_st)
        CALC_IDLE: begin
          if (recalc_req) begin
            step    <= '0;
            calc_st <= CALC_LOAD;
          end
        end
        CALC_LOAD: begin
          div_start <= 1'b1;
          calc_st   <= CALC_WAIT;
        end
        CALC_WAIT: begin
          if (div_done) begin
            if (step == STEP_LAST) begin
              calc_st <= CALC_IDLE;
            end else begin
              step    <= step + 1'b1;
              calc_st <= CALC_LOAD;
            end
          end
        end
        default: calc_st <= CALC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < swsm_pkg::N_LIMITS; i++) begin
        up_thr[i]  <= '0;
        rel_thr[i] <= '0;
      end
    end else if (ce && calc_st == CALC_WAIT && div_done) begin
      if (step[0]) begin
        rel_thr[lim_idx] <= up_thr[lim_idx] - quo_sat;
      end else begin
        up_thr[lim_idx] <= quo_sat;
      end
    end
  end

  // ==========================================================
  // Pin synchroniser and edge tracking
  swsm_pkg::swsm_pins_t pin_s1;
  swsm_pkg::swsm_pins_t pin_s2;
  swsm_pkg::swsm_pins_t pin_d;
  logic                 rise1;
  logic                 rise2;
  logic                 phase_evt;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_s1 <= swsm_pkg::PINS_IDLE;
      pin_s2 <= swsm_pkg::PINS_IDLE;
      pin_d  <= swsm_pkg::PINS_IDLE;
    end else if (ce) begin
      pin_s1 <= pins;
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  assign rise1 = pin_s2.s1_a && !pin_d.s1_a;
  assign rise2 = pin_s2.s2_a && !pin_d.s2_a;
  // Both quadrature phases moving together means a lost phase
  assign phase_evt = (has_enc1 && (pin_s2.s1_a != pin_d.s1_a) && (pin_s2.s1_b != pin_d.s1_b)) ||
                     (s2_enc && (pin_s2.s2_a != pin_d.s2_a) && (pin_s2.s2_b != pin_d.s2_b));

  // ==========================================================
  // Gate counting
  logic [GW-1:0] gate_cnt;
  logic          gate_end;
  logic [FW-1:0] cnt1;
  logic [FW-1:0] cnt2;
  logic [FW-1:0] f1_meas;
  logic [FW-1:0] f2_meas;
  logic [WW-1:0] f1_w;
  logic [WW-1:0] f2_w;

  assign gate_end = (gate_cnt == GATE_LAST);
  assign f1_w = WW'(cnt1) * WW'(swsm_pkg::GATES_PER_S);
  assign f2_w = WW'(cnt2) * WW'(swsm_pkg::GATES_PER_S);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gate_cnt <= '0;
      cnt1     <= '0;
      cnt2     <= '0;
      f1_meas  <= '0;
      f2_meas  <= '0;
    end else if (ce) begin
      if (gate_end) begin
        gate_cnt <= '0;
        cnt1     <= FW'(rise1);
        cnt2     <= FW'(rise2);
        f1_meas  <= (f1_w > WW'(FREQ_MAX)) ? FREQ_MAX : f1_w[FW-1:0];
        f2_meas  <= (f2_w > WW'(FREQ_MAX)) ? FREQ_MAX : f2_w[FW-1:0];
      end else begin
        gate_cnt <= gate_cnt + 1'b1;
        if (rise1 && cnt1 != FREQ_MAX) cnt1 <= cnt1 + 1'b1;
        if (rise2 && cnt2 != FREQ_MAX) cnt2 <= cnt2 + 1'b1;
      end
    end
  end

  // ==========================================================
  // Faults and effective frequency
  logic          unavail;
  logic          ana_fault;
  logic          phase_flag;
  logic          mismatch;
  logic [FW-1:0] freq;
  logic [WW-1:0] lhs;
  logic [WW-1:0] rhs;
  logic [WW-1:0] diff;
  logic [WW-1:0] big;

  assign unavail   = !pin_s2.s1_ok || (has_s2 && !pin_s2.s2_ok) ||
                     ((has_enc1 || s2_enc) && !pin_s2.pwr_ok);
  assign ana_fault = (has_enc1 || s2_enc) && !cfg.analog_off && !pin_s2.ana_ok;

  // Compare both sensors in a common speed unit
  always_comb begin
    if (cfg.sensor_linear) begin
      lhs = WW'(f1_meas) * WW'(res1) * WW'(gear);
      rhs = WW'(f2_meas) * WW'(res2);
    end else begin
      lhs = WW'(f1_meas) * WW'(res2) * WW'(gear);
      rhs = WW'(f2_meas) * WW'(res1);
    end
    diff = (lhs > rhs) ? lhs - rhs : rhs - lhs;
    big  = (lhs > rhs) ? lhs : rhs;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase_flag <= 1'b0;
      mismatch   <= 1'b0;
    end else if (ce) begin
      if (phase_evt) begin
        phase_flag <= 1'b1;
      end else if (gate_end) begin
        phase_flag <= 1'b0;
      end
      if (!has_s2) begin
        mismatch <= 1'b0;
      end else begin
        mismatch <= (diff * WW'(swsm_pkg::PERCENT)) > (big * WW'(swsm_pkg::MISMATCH_PCT));
      end
    end
  end

  // Saturation follows at once so a pulled cable is not read as standstill when saturate_high_choice is set
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      freq <= '0;
    end else if (ce) begin
      if (unavail) begin
        freq <= cfg.saturate_high_choice ? FREQ_SAT : '0;
      end else if (gate_end) begin
        freq <= (f1_w > WW'(FREQ_MAX)) ? FREQ_MAX : f1_w[FW-1:0];
      end
    end
  end

  // ==========================================================
  // Hysteresis comparators, every cycle
  logic over_hi;
  logic under_lo;
  logic next_over_hi;
  logic next_under_lo;

  always_comb begin
    next_over_hi  = over_hi;
    next_under_lo = under_lo;
    if (freq > up_thr[swsm_pkg::LIMIT_HI]) begin
      next_over_hi = 1'b1;
    end else if (freq < rel_thr[swsm_pkg::LIMIT_HI]) begin
      next_over_hi = 1'b0;
    end
    if (freq < rel_thr[swsm_pkg::LIMIT_LO]) begin
      next_under_lo = 1'b1;
    end else if (freq > up_thr[swsm_pkg::LIMIT_LO]) begin
      next_under_lo = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      over_hi    <= 1'b0;
      under_lo   <= 1'b1;
      window_out <= 1'b0;
      zero_out   <= 1'b1;
    end else if (ce) begin
      over_hi    <= next_over_hi;
      under_lo   <= next_under_lo;
      window_out <= !next_over_hi && !next_under_lo;
      if (freq > up_thr[swsm_pkg::LIMIT_ZERO]) begin
        zero_out <= 1'b0;
      end else if (freq < rel_thr[swsm_pkg::LIMIT_ZERO]) begin
        zero_out <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Direction, error and speed outputs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dir_out        <= 1'b0;
      error_out      <= 1'b0;
      speed_freq_out <= '0;
    end else if (ce) begin
      if (!(cfg.dir_en && has_enc1)) begin
        dir_out <= 1'b0;
      end else if (rise1) begin
        dir_out <= pin_s2.s1_b;
      end
      error_out      <= cfg.err_en && (unavail || ana_fault || phase_flag || mismatch);
      speed_freq_out <= cfg.speed_out_en ? freq : '0;
    end
  end

  // ==========================================================
  // Register read port
  logic [swsm_pkg::STAT_W-1:0] status;

  always_comb begin
    status = '0;
    status[swsm_pkg::ST_WINDOW]   = window_out;
    status[swsm_pkg::ST_ZERO]     = zero_out;
    status[swsm_pkg::ST_DIR]      = dir_out;
    status[swsm_pkg::ST_ERROR]    = error_out;
    status[swsm_pkg::ST_BUSY]     = (calc_st != CALC_IDLE) || recalc_req;
    status[swsm_pkg::ST_UNAVAIL]  = unavail;
    status[swsm_pkg::ST_PHASE]    = phase_flag;
    status[swsm_pkg::ST_MISMATCH] = mismatch;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= '0;
      if (rd_en) begin
        case (addr)
          swsm_pkg::OFF_CTRL:   rdata <= 32'(cfg);
          swsm_pkg::OFF_RES1:   rdata <= 32'(res1);
          swsm_pkg::OFF_RES2:   rdata <= 32'(res2);
          swsm_pkg::OFF_GEAR:   rdata <= 32'(gear);
          swsm_pkg::OFF_PITCH:  rdata <= 32'(pitch);
          swsm_pkg::OFF_HYST:   rdata <= 32'(hyst);
          swsm_pkg::OFF_HIGH:   rdata <= 32'(spd_lim[swsm_pkg::LIMIT_HI]);
          swsm_pkg::OFF_LOW:    rdata <= 32'(spd_lim[swsm_pkg::LIMIT_LO]);
          swsm_pkg::OFF_ZERO:   rdata <= 32'(spd_lim[swsm_pkg::LIMIT_ZERO]);
          swsm_pkg::OFF_STATUS: rdata <= 32'(status);
          swsm_pkg::OFF_FREQ:   rdata <= 32'(freq);
          default:              rdata <= '0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [logic/swsm_pkg.sv]
`default_nettype none
package swsm_pkg;
  // ==========================================================
  // Widths
  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 8;
  localparam int FREQ_W  = 20;
  localparam int SPEED_W = 16;
  localparam int RES_W   = 16;
  localparam int GEAR_W  = 8;
  localparam int HYST_W  = 7;
  localparam int NUM_W   = 48;
  localparam int WIDE_W  = 56;
  localparam int CFG_W   = 10;
  localparam int STAT_W  = 8;
  localparam int PIN_W   = 8;

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RES1   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RES2   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_GEAR   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_PITCH  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_HYST   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_HIGH   = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_LOW    = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_ZERO   = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_FREQ   = 8'h28;

  // ==========================================================
  // Reset values
  localparam logic [CFG_W-1:0]   CFG_RESET  = 10'h200;
  localparam logic [RES_W-1:0]   RES_RESET  = 16'h0001;
  localparam logic [GEAR_W-1:0]  GEAR_RESET = 8'h01;
  localparam logic [RES_W-1:0]   PITCH_RESET = 16'h0001;
  localparam logic [HYST_W-1:0]  HYST_RESET = 7'h00;
  localparam logic [SPEED_W-1:0] SPEED_RESET = 16'h0000;

  // ==========================================================
  // Status bit positions
  localparam int ST_WINDOW   = 0;
  localparam int ST_ZERO     = 1;
  localparam int ST_DIR      = 2;
  localparam int ST_ERROR    = 3;
  localparam int ST_BUSY     = 4;
  localparam int ST_UNAVAIL  = 5;
  localparam int ST_PHASE    = 6;
  localparam int ST_MISMATCH = 7;

  // ==========================================================
  // Conversion and timing
  localparam int CLK_HZ       = 20_000_000;
  localparam int GATE_TIME_MS = 100;
  localparam int MS_PER_S     = 1000;
  localparam int GATE_CYCLES_DEF = CLK_HZ / MS_PER_S * GATE_TIME_MS;
  localparam int GATES_PER_S  = MS_PER_S / GATE_TIME_MS;
  localparam int SEC_PER_MIN  = 60;
  localparam int MILLI        = 1000;
  localparam int PERCENT      = 100;
  localparam int SAT_HIGH_HZ  = 650000;
  localparam int MISMATCH_PCT = 20;
  localparam int LIMIT_HI     = 0;
  localparam int LIMIT_LO     = 1;
  localparam int LIMIT_ZERO   = 2;
  localparam int N_LIMITS     = 3;
  localparam int N_STEPS      = 6;

  typedef enum logic [2:0] {
    SWSM_MD_ENC,
    SWSM_MD_PROX,
    SWSM_MD_ENC_PROX,
    SWSM_MD_PROX_PROX,
    SWSM_MD_ENC_ENC
  } swsm_mdev_t;

  typedef struct packed {
    logic       saturate_high_choice;
    logic       speed_out_en;
    logic       err_en;
    logic       dir_en;
    logic       analog_off;
    swsm_mdev_t mdev;
    logic       sensor_linear;
    logic       axis_linear;
  } swsm_cfg_t;

  typedef struct packed {
    logic ana_ok;
    logic pwr_ok;
    logic s2_ok;
    logic s1_ok;
    logic s2_b;
    logic s2_a;
    logic s1_b;
    logic s1_a;
  } swsm_pins_t;

  // Sensor healthy, lines low: synchroniser reset state
  localparam swsm_pins_t PINS_IDLE = 8'hf0;
endpackage
`default_nettype wire

// [testbench/swsm_enc_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ====================
// Sensor 1 encoder; zero period freezes lines
module swsm_enc_model (
  input  wire logic [7:0]          period,
  input  wire logic                mclk,
  input  wire logic                ccw,
  input  wire logic [3:0]          ok,
  output var swsm_pkg::swsm_pins_t pins
);
  int cnt = 0;
  initial pins = 8'hf0;
  // B leads A when counterclockwise
  always @(posedge mclk) begin
    if (period != 8'h00) begin
      cnt = (cnt + 1) % period;
      pins.s1_a <= cnt < period / 2;
      pins.s1_b <= ccw ^ ((cnt + period / 4) % period >= period / 2);
    end
    {pins.ana_ok, pins.pwr_ok, pins.s2_ok, pins.s1_ok} <= ok; // Healthy reads high
  end
endmodule
`default_nettype wire

// [testbench/swsm_monitor_props.sv]
`timescale 1ns/100ps
`default_nettype none
// ====================
// Port checks; CTRL is shadowed from bus writes
module swsm_monitor_chk #(
  parameter int GATE_CYCLES = 200
) (
  input wire logic                 mclk,
  input wire logic                 rst_n,
  input wire logic                 ce,
  input wire logic [7:0]           addr,
  input wire logic [31:0]          wdata,
  input wire logic                 wr_en,
  input wire logic                 rd_en,
  input wire logic [31:0]          rdata,
  input wire swsm_pkg::swsm_pins_t pins,
  input wire logic                 window_out,
  input wire logic                 zero_out,
  input wire logic                 dir_out,
  input wire logic                 error_out,
  input wire logic [19:0]          speed_freq_out
);
  swsm_pkg::swsm_cfg_t ctl;
  logic                enc;
  assign enc = ctl.mdev inside {swsm_pkg::SWSM_MD_ENC, swsm_pkg::SWSM_MD_ENC_PROX, swsm_pkg::SWSM_MD_ENC_ENC};
  always_ff @(posedge mclk) begin
    if (!rst_n)
      ctl <= swsm_pkg::CFG_RESET;
    else if (ce && wr_en && addr == swsm_pkg::OFF_CTRL)
      ctl <= wdata[9:0];
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_rd_idle; !rd_en |=> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_sat; (ctl.speed_out_en && !pins.s1_ok && $stable(ctl)) [*5] |->
    speed_freq_out == (ctl.saturate_high_choice ? 20'd650000 : 20'd0); endproperty
  a_sat: assert property (p_sat) else $error("saturation value");
  property p_err_off; !ctl.err_en && !$past(ctl.err_en) |-> !error_out; endproperty
  a_err_off: assert property (p_err_off) else $error("error while disabled");
  property p_err_unav; (ctl.err_en && !pins.s1_ok) [*5] |-> error_out; endproperty
  a_err_unav: assert property (p_err_unav) else $error("missing sensor not flagged");
  property p_ana; (ctl.err_en && !ctl.analog_off && enc && !pins.ana_ok) [*5] |-> error_out; endproperty
  a_ana: assert property (p_ana) else $error("analog fault not flagged");
  property p_spd_off; !ctl.speed_out_en && !$past(ctl.speed_out_en) |-> speed_freq_out == 20'h0; endproperty
  a_spd_off: assert property (p_spd_off) else $error("speed out while off");
  property p_dir; $rose(dir_out) |-> ctl.dir_en && ($past(pins.s1_b, 3) || $past(pins.s1_b, 4)); endproperty
  a_dir: assert property (p_dir) else $error("direction rise without B high");
  property p_gate; ctl.speed_out_en |-> speed_freq_out % 20'd10 == 20'd0; endproperty
  a_gate: assert property (p_gate) else $error("freq not whole gate count");
endmodule
bind swsm_monitor swsm_monitor_chk #(.GATE_CYCLES(GATE_CYCLES)) i_swsm_monitor_chk (
  .mclk(mclk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
  .rdata(rdata), .pins(pins), .window_out(window_out), .zero_out(zero_out), .dir_out(dir_out),
  .error_out(error_out), .speed_freq_out(speed_freq_out));
`default_nettype wire

// [testbench/test_speed_window_standstill_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module test_speed_window_standstill_monitor;
  localparam int G = 200;
  logic [7:0]           period = 8'h00;
  logic                 mclk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 wr_en = 1'b0;
  logic                 rd_en = 1'b0;
  logic                 ccw = 1'b0;
  logic [7:0]           addr = 8'h00;
  logic [31:0]          wdata = 32'h0;
  logic [31:0]          rd;
  logic [31:0]          rdata;
  logic [3:0]           ok = 4'hf;
  logic                 window_out;
  logic                 zero_out;
  logic                 dir_out;
  logic                 error_out;
  logic [19:0]          speed_freq_out;
  swsm_pkg::swsm_pins_t pins;
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 32'h4ee4;
  int k, i, f, m;
  int ov = 0, un = 1, zr = 1;
  int per[7] = '{10, 4, 7, 10, 7, 100, 0};
  int cv[7] = '{32'h3c0, 60, 10, 300, 100, 50, 1000};
  logic [7:0] ca[7] = '{8'h00, 8'h04, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h10};
  logic [3:0] fault[5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1};
  initial forever #25 mclk = ~mclk;
  swsm_monitor #(.GATE_CYCLES(G)) i_swsm_monitor (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pins(pins), .window_out(window_out),
    .zero_out(zero_out), .dir_out(dir_out), .error_out(error_out), .speed_freq_out(speed_freq_out));
  swsm_enc_model i_swsm_enc_model (.period(period), .mclk(mclk), .ccw(ccw), .ok(ok), .pins(pins));
  function automatic int up(int s);
    return m == 0 ? s * cv[1] / 60 : m == 1 ? s * 1000 * cv[1] / (60 * cv[6]) : s * 1000 / cv[1];
  endfunction
  function automatic int rl(int s);
    return up(s) - up(s) * 10 / 100;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Strobe one cycle, then one idle cycle so no signal is driven twice in a step
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
    wr_en <= w;
    rd_en <= !w;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(negedge mclk);
    rd = rdata;
    @(posedge mclk);
  endtask
  task automatic idle();
    for (i = 0; i < 400; i++) begin
      acc(1'b0, swsm_pkg::OFF_STATUS, 32'h0);
      if (rd[swsm_pkg::ST_BUSY] === 1'b0)
        return;
    end
    error_cnt++;
    summarize();
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk("window", 0, window_out);
    chk("zero", 1, zero_out);
    @(posedge mclk);
    acc(1'b0, swsm_pkg::OFF_CTRL, 32'h0);
    chk("ctrl", 32'h200, rd);
    acc(1'b0, 8'h30, 32'h0);
    chk("unmapped", 0, rd);
    k = $random(seed);
    acc(1'b1, swsm_pkg::OFF_GEAR, k);
    acc(1'b0, swsm_pkg::OFF_GEAR, 32'h0);
    chk("gear", k & 32'hff, rd);
    acc(1'b1, swsm_pkg::OFF_FREQ, $random(seed));
    acc(1'b0, swsm_pkg::OFF_FREQ, 32'h0);
    chk("freq_ro", 0, rd);
    // Rotary, linear axis with rotary sensor, linear sensor
    for (m = 0; m < 3; m++) begin
      cv[0] = 32'h3c0 + m + m / 2;
      cv[1] = m == 2 ? 1000 : 60;
      for (k = 0; k < 7; k++)
        acc(1'b1, ca[k], cv[k]);
      idle();
      for (k = 0; k < 7; k++) begin
        period <= per[k][7:0];
        if (per[k] > 0)
          ccw <= k[0];
        f = per[k] > 0 ? 10 * G / per[k] : 0;
        if (f > up(300)) ov = 1; else if (f < rl(300)) ov = 0;
        if (f < rl(100)) un = 1; else if (f > up(100)) un = 0;
        if (f > up(50)) zr = 0; else if (f < rl(50)) zr = 1;
        repeat (3 * G + 10) @(negedge mclk);
        chk("window", !ov && !un, window_out);
        chk("zero", zr, zero_out);
        chk("dir", ccw, dir_out);
        chk("freq", 1, speed_freq_out + 10 >= f && speed_freq_out <= f + 10);
        $display("speed step %0d done", k);
        @(posedge mclk);
      end
    end
    for (k = 0; k < 5; k++) begin
      acc(1'b1, swsm_pkg::OFF_CTRL, k == 4 ? 32'h1c0 : 32'h3c0);
      ok <= 4'hf ^ fault[k];
      repeat (20) @(negedge mclk);
      chk("error", fault[k] != 4'h2, error_out);
      chk("sat", (fault[k] == 4'h1 || fault[k] == 4'h4) && k < 4 ? 650000 : 0, speed_freq_out);
      @(posedge mclk);
      ok <= 4'hf;
      repeat (3 * G) @(negedge mclk);
      chk("error", 0, error_out);
      $display("fault step %0d done", k);
      @(posedge mclk);
    end
    summarize();
  end
endmodule
`default_nettype wire
